/* rtl/rdctl_consts.svh */
// Notes on behaviour
// (R1) Stop waits for in-flight operation to finish.
// (R2) Descriptor-mode stop flushes, drains write-backs, then halts.
// (R3) Direct-mode stop flushes; stream may end early.
// (R4) Halted flag rises once engine truly halted.
// (R5) Engine clears run_stop itself on error.
// (R6) Software may write run_stop 0 anytime.
// (R7) Writing run_stop 1 starts; halted drops.
// (R8) Bit 1 ignores writes, reads 1.
// (R9) Soft reset bit resets engine gracefully.
// (R10) Either channel's soft reset resets whole engine.
// (R11) Soft reset bit reads 1 while resetting.
// (R12) Keyhole makes reads fixed-address bursts.
// (R13) Software changes keyhole only when idle, burst<=16.
// (R14) Keyhole ignored in multichannel or direct mode.
// (R15) Cyclic enable ignores descriptor completed flag.
// (R16) Software changes cyclic enable only when idle.
// (R17) Cyclic enable ignored in multichannel mode.
// (R18) Writes take all 32 data bits, ignore strobes.
// (R19) Hardware reset: low bits zero, bit 1 one.
`ifndef RDCTL_CONSTS_SVH
`define RDCTL_CONSTS_SVH
`define RDCTL_CTRL_OFFSET 8'h00
`define RDCTL_BIT_RUN 0
`define RDCTL_BIT_ONE 1
`define RDCTL_BIT_SRST 2
`define RDCTL_BIT_KEYHOLE 3
`define RDCTL_BIT_CYCLIC 4
`define RDCTL_CTRL_RESET 32'h0000_0002
`define RDCTL_SRST_HOLD 4'h4
`endif

/* rtl/rdctl_pkg.sv */
package rdctl_pkg;
  typedef enum logic [1:0] {
    RDCTL_HALTED,
    RDCTL_RUNNING,
    RDCTL_STOPPING
  } rdctl_state_t;
endpackage

/* rtl/rdctl_srst_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdctl_consts.svh"
// Soft reset sequencer: waits for the engine to drain, then pulses a reset.
module rdctl_srst_seq (
  input wire logic core_clk_i, // Engine clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic req_i, // Soft reset request pulse.
  input wire logic drained_i, // Engine has no work in flight.
  output logic busy_o, // Reset in progress.
  output logic flush_o, // Ask engine to flush pending work.
  output logic clear_o // One-cycle reset of all registers.
);
  logic busy_q;
  logic busy_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic clr_q;
  wire logic hold_done;

  // The clear fires after a short hold once the engine reports drained.
  assign hold_done = busy_q && drained_i && (cnt_q == `RDCTL_SRST_HOLD);
  assign busy_d = (busy_q && !hold_done) || req_i;
  assign cnt_d = (!busy_q || !drained_i) ? 4'h0 :
                 (cnt_q == `RDCTL_SRST_HOLD) ? cnt_q : cnt_q + 4'h1;

  // Busy stays high through the clear cycle so software never sees a gap.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      clr_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      clr_q <= hold_done;
    end
  end

  assign busy_o = busy_q || clr_q; // see (R11)
  assign flush_o = busy_q; // see (R9)
  assign clear_o = clr_q; // see (R10)

  AST_SRST_CLEAR_AFTER_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R9)
    hold_done |=> clear_o && busy_o)
    else $error("soft reset clear did not follow hold");
  AST_SRST_BUSY_UNTIL_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R11)
    $rose(busy_q) |-> busy_o throughout (##[0:1000] clear_o))
    else $error("soft reset busy dropped before clear");
endmodule
`default_nettype wire

/* rtl/rdctl_run_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdctl_consts.svh"
// Run/stop, soft reset, keyhole and cyclic bits of the read channel control register.
module rdctl_run_ctrl #(
  parameter int ADDR_W = 8 // Register port address width.
) (
  input wire logic core_clk_i, // Engine clock, 10 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic reg_wr_i, // Register write strobe.
  input wire logic reg_rd_i, // Register read strobe.
  input wire logic [ADDR_W-1:0] reg_addr_i, // Register byte offset.
  input wire logic [31:0] reg_wdata_i, // Write data.
  input wire logic [3:0] reg_wstrb_i, // Byte strobes, ignored.
  output logic [31:0] reg_rdata_o, // Read data, registered.
  input wire logic peer_srst_i, // Soft reset asked by write channel.
  input wire logic sg_mode_i, // Descriptor mode when high, else direct.
  input wire logic multichan_i, // Engine built with multiple channels.
  input wire logic op_busy_i, // A data operation is in flight.
  input wire logic wb_pending_i, // Descriptor write-backs still queued.
  input wire logic error_i, // Engine error pulse.
  output logic run_o, // Channel allowed to start new work.
  output logic flush_o, // Flush pending commands, cut stream short.
  output logic halted_o, // Halted flag for the status register.
  output logic srst_busy_o, // Soft reset in progress, whole engine.
  output logic engine_clear_o, // One-cycle soft reset of all registers.
  output logic fixed_burst_o, // Use fixed-address read bursts.
  output logic ignore_done_o // Fetch ignores descriptor completed flag.
);
  rdctl_pkg::rdctl_state_t state_q;
  rdctl_pkg::rdctl_state_t state_d;
  logic run_q;
  logic keyhole_q;
  logic cyclic_q;
  logic [31:0] rdata_q;
  wire logic sel_ctrl;
  wire logic wr_ctrl;
  wire logic srst_req;
  wire logic srst_busy;
  wire logic srst_flush;
  wire logic srst_clear;
  wire logic drained;
  wire logic run_d;
  wire logic [31:0] ctrl_view;
  wire logic unused_strb;

  // Strobes are deliberately ignored; every write carries a full word.
  assign unused_strb = ^reg_wstrb_i;
  assign sel_ctrl = (reg_addr_i == ADDR_W'(`RDCTL_CTRL_OFFSET));
  assign wr_ctrl = reg_wr_i && sel_ctrl; // see (R18)
  assign srst_req = (wr_ctrl && reg_wdata_i[`RDCTL_BIT_SRST]) || peer_srst_i; // see (R10)

  // Drained means no operation and, in descriptor mode, no write-back left.
  assign drained = !op_busy_i && !(sg_mode_i && wb_pending_i); // see (R2)

  rdctl_srst_seq i_rdctl_srst_seq (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .req_i(srst_req),
    .drained_i(drained),
    .busy_o(srst_busy),
    .flush_o(srst_flush),
    .clear_o(srst_clear)
  );

  // Error wins over a run write in the same cycle, so a fault always stops.
  assign run_d = error_i ? 1'b0 : // see (R5)
                 wr_ctrl ? reg_wdata_i[`RDCTL_BIT_RUN] : run_q; // see (R6)

  // Control bits; the soft reset clear returns them to their reset values.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q <= 1'b0; // see (R19)
      keyhole_q <= 1'b0;
      cyclic_q <= 1'b0;
    end else if (srst_clear || srst_busy) begin
      run_q <= 1'b0; // see (R10)
      keyhole_q <= 1'b0;
      cyclic_q <= 1'b0;
    end else begin
      run_q <= run_d;
      if (wr_ctrl) begin
        keyhole_q <= reg_wdata_i[`RDCTL_BIT_KEYHOLE];
        cyclic_q <= reg_wdata_i[`RDCTL_BIT_CYCLIC];
      end
    end
  end

  // Run state: halting waits for in-flight work to drain.
  always_comb begin
    state_d = state_q;
    case (state_q)
      rdctl_pkg::RDCTL_HALTED: begin
        if (run_q) begin
          state_d = rdctl_pkg::RDCTL_RUNNING; // see (R7)
        end
      end
      rdctl_pkg::RDCTL_RUNNING: begin
        if (!run_q) begin
          state_d = drained ? rdctl_pkg::RDCTL_HALTED : rdctl_pkg::RDCTL_STOPPING; // see (R1)
        end
      end
      rdctl_pkg::RDCTL_STOPPING: begin
        if (drained) begin
          state_d = rdctl_pkg::RDCTL_HALTED; // see (R4)
        end
      end
      default: begin
        state_d = rdctl_pkg::RDCTL_HALTED;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= rdctl_pkg::RDCTL_HALTED;
    end else if (srst_clear) begin
      state_q <= rdctl_pkg::RDCTL_HALTED;
    end else begin
      state_q <= state_d;
    end
  end

  // Register view: bit 1 is a constant one, bits above 4 read zero here.
  assign ctrl_view = {27'h0, cyclic_q, keyhole_q, srst_busy, 1'b1, run_q}; // see (R8)

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0;
    end else if (reg_rd_i) begin
      rdata_q <= sel_ctrl ? ctrl_view : 32'h0;
    end
  end

  // Outputs; stopping flushes queued commands in either mode.
  assign reg_rdata_o = rdata_q;
  assign run_o = (state_q == rdctl_pkg::RDCTL_RUNNING) && run_q;
  assign flush_o = (state_q == rdctl_pkg::RDCTL_STOPPING) || srst_flush; // see (R3)
  assign halted_o = (state_q == rdctl_pkg::RDCTL_HALTED);
  assign srst_busy_o = srst_busy; // see (R11)
  assign engine_clear_o = srst_clear;
  // Keyhole only applies to single-channel descriptor operation.
  assign fixed_burst_o = keyhole_q && sg_mode_i && !multichan_i; // see (R14) see (R12)
  assign ignore_done_o = cyclic_q && !multichan_i; // see (R15) see (R17)

  AST_STOP_WAITS_DRAIN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R1)
    (state_q == rdctl_pkg::RDCTL_STOPPING && !drained && !srst_clear) |=> !halted_o)
    else $error("halted before in-flight work finished");
  AST_HALT_AFTER_DRAIN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R4)
    (state_q == rdctl_pkg::RDCTL_STOPPING && drained) |=> halted_o)
    else $error("halted flag late after drain");
  AST_WB_BLOCKS_HALT: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R2)
    (state_q == rdctl_pkg::RDCTL_STOPPING && sg_mode_i && wb_pending_i && !srst_clear)
      |=> !halted_o)
    else $error("halted with write-backs pending");
  AST_STOP_FLUSHES: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R3)
    (state_q == rdctl_pkg::RDCTL_STOPPING) |-> flush_o)
    else $error("no flush while stopping");
  AST_ERROR_CLEARS_RUN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R5)
    error_i |=> !run_q)
    else $error("run not cleared on error");
  AST_RUN_STARTS: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R7)
    (wr_ctrl && reg_wdata_i[`RDCTL_BIT_RUN] && !error_i && !srst_busy && halted_o)
      |=> ##1 !halted_o)
    else $error("halted did not drop after run");
  AST_BIT1_ONE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R8)
    $past(reg_rd_i) && $past(sel_ctrl) |-> reg_rdata_o[1])
    else $error("constant bit read as zero");
  AST_FULL_WORD_WRITE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R18)
    (wr_ctrl && !srst_busy && !srst_req && reg_wstrb_i == 4'h0) |=>
      keyhole_q == $past(reg_wdata_i[`RDCTL_BIT_KEYHOLE]))
    else $error("write depended on strobes");
  AST_SRST_CLEARS_ALL: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R10)
    srst_clear |=> !run_q && !keyhole_q && !cyclic_q && halted_o)
    else $error("soft reset left state behind");
  AST_SRST_SHOWN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R11)
    srst_req |=> srst_busy_o)
    else $error("soft reset not shown busy");
  AST_KEYHOLE_GATED: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R14)
    (multichan_i || !sg_mode_i) |-> !fixed_burst_o)
    else $error("keyhole active where it must not be");
  AST_CYCLIC_GATED: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R17)
    multichan_i |-> !ignore_done_o)
    else $error("cyclic active in multichannel");
  AST_CYCLIC_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R15)
    (cyclic_q && !multichan_i) |-> ignore_done_o)
    else $error("cyclic bit not applied");

  // New work is never let out while stopping or halted, and halted never shows while running.
  AST_NO_RUN_STOPPING: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R1)
    (state_q == rdctl_pkg::RDCTL_STOPPING) |-> !run_o)
    else $error("new work allowed while stopping");
  AST_HALTED_NO_RUN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R4)
    halted_o |-> !run_o)
    else $error("run allowed while halted");
  AST_RUN_NOT_HALTED: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R7)
    run_o |-> !halted_o)
    else $error("halted shown while running");
  AST_RUN_WRITE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R7)
    (wr_ctrl && reg_wdata_i[`RDCTL_BIT_RUN] && !error_i && !srst_busy) |=> run_q)
    else $error("run write not taken");
  AST_ERROR_DROPS_RUN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R5)
    error_i |=> !run_o)
    else $error("run output stayed up after error");

  // Soft reset: bits held low and work flushed, and the clear waits for the drain.
  AST_SRST_BITS_LOW: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R9)
    srst_busy |=> !run_q && !keyhole_q && !cyclic_q)
    else $error("control bits kept during soft reset");
  AST_SRST_FLUSHES: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R9)
    (srst_busy && !srst_clear) |-> flush_o)
    else $error("no flush during soft reset");
  AST_SRST_WAITS_DRAIN: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R9)
    (srst_busy && !drained) |=> !srst_clear)
    else $error("soft reset cleared before drain");
  // A request landing in the clear cycle starts a new reset, so it is left out here.
  AST_SRST_RESTORES: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R10)
    (srst_clear && !srst_flush && !srst_req) |=> ctrl_view == `RDCTL_CTRL_RESET)
    else $error("register view not back at reset value");
  AST_SRST_READ_BUSY: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R11)
    (reg_rd_i && sel_ctrl) |=> reg_rdata_o[`RDCTL_BIT_SRST] == $past(srst_busy))
    else $error("soft reset bit read wrong");

  // Keyhole and cyclic bits follow the written word and reach their outputs.
  AST_KEYHOLE_APPLIES: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R12)
    (keyhole_q && sg_mode_i && !multichan_i) |-> fixed_burst_o)
    else $error("keyhole bit not applied");
  AST_KEYHOLE_WRITE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R12)
    (wr_ctrl && !srst_busy) |=> keyhole_q == $past(reg_wdata_i[`RDCTL_BIT_KEYHOLE]))
    else $error("keyhole write not taken");
  AST_CYCLIC_WRITE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see (R15)
    (wr_ctrl && !srst_busy) |=> cyclic_q == $past(reg_wdata_i[`RDCTL_BIT_CYCLIC]))
    else $error("cyclic write not taken");

  COV_RUN_STOP: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_q == rdctl_pkg::RDCTL_RUNNING ##[1:20] state_q == rdctl_pkg::RDCTL_STOPPING);
  COV_SOFT_RESET: cover property (@(posedge core_clk_i) disable iff (!nrst_i) srst_clear);
  COV_ERROR_STOP: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    error_i && run_q);
  // A descriptor-mode stop that has to wait for write-backs.
  COV_WB_STOP: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_q == rdctl_pkg::RDCTL_STOPPING && sg_mode_i && wb_pending_i);
  // A soft reset started by the other channel.
  COV_PEER_SRST: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    peer_srst_i ##1 srst_busy_o);
endmodule
`default_nettype wire

/* verification/rdctl_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the data path: it picks up work while the channel runs and drains when let go.
module rdctl_engine_model (
  input wire logic core_clk_i, // Engine clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic sg_mode_i, // Descriptor mode.
  input wire logic run_i, // Channel may start work.
  input wire logic stall_i, // Bench keeps work in flight.
  output logic op_busy_o, // Work in flight.
  output logic wb_pending_o // Write-backs queued.
);
  // Work ends only when the stall is lifted, so stops see both prompt and slow drains.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_busy_o <= 1'b0;
      wb_pending_o <= 1'b0;
    end else if (!stall_i) begin
      op_busy_o <= 1'b0;
      wb_pending_o <= op_busy_o && sg_mode_i;
    end else if (run_i) begin
      op_busy_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_rdctl_run_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_rdctl_run_ctrl;
  logic clk, nrst, wr, rd, peer, sg, mc, err, stall;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic busy, wbp, run, flush, halted, sbusy, clr, fixb, igd;
  int mismatches = 0;
  int total_checks = 0;
  rdctl_run_ctrl i_rdctl_run_ctrl (.core_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wstrb_i(wstrb),
    .reg_rdata_o(rdata), .peer_srst_i(peer), .sg_mode_i(sg), .multichan_i(mc),
    .op_busy_i(busy), .wb_pending_i(wbp), .error_i(err), .run_o(run), .flush_o(flush),
    .halted_o(halted), .srst_busy_o(sbusy), .engine_clear_o(clr), .fixed_burst_o(fixb),
    .ignore_done_o(igd));
  rdctl_engine_model i_rdctl_engine_model (.core_clk_i(clk), .nrst_i(nrst), .sg_mode_i(sg),
    .run_i(run), .stall_i(stall), .op_busy_o(busy), .wb_pending_o(wbp));
  // Free-running engine clock, 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Upper data bits and strobes are random: the register must take the data word whole.
  task automatic wr_reg(input logic [7:0] a, input logic [4:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = {$urandom() & 32'hFFFFFFE0} | {27'h0, d};
    wstrb = 4'($urandom());
    @(posedge clk) #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    d = rdata;
  endtask
  // Expected control word: bit 1 always set, reserved bits clear.
  function automatic logic [31:0] ctl(input logic [4:0] b);
    return {27'h0, b | 5'h02};
  endfunction
  // Watchdog after 20000 cycles: the whole sequence needs well under that.
  initial begin
    #(20000 * 100);
    mismatches++;
    give_verdict();
  end
  initial begin
    {wr, rd, peer, sg, mc, err, stall, addr, wdata, wstrb} = '0;
    nrst = 1'b0;
    void'($urandom(32'h509F717B));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    rd_reg(8'h00, v);
    chk(v, 32'h0000_0002);
    chk({31'h0, halted}, 32'h1);
    rd_reg(8'h10, v);
    chk(v, 32'h0);
    $display("test reset done");
    // Keyhole and cyclic set while idle, across every build and mode pairing.
    for (int i = 0; i < 4; i++) begin
      {sg, mc} = 2'(i);
      wr_reg(8'h00, 5'h18);
      rd_reg(8'h00, v);
      chk(v, ctl(5'h18));
      chk({31'h0, fixb}, {31'h0, sg & ~mc});
      chk({31'h0, igd}, {31'h0, ~mc});
      wr_reg(8'h00, 5'h02);
      chk({30'h0, fixb, igd}, 32'h0);
    end
    $display("test modes done");
    // Stop with work in flight in both modes.
    for (int m = 0; m < 2; m++) begin
      {sg, mc} = {1'(m), 1'b0};
      stall = 1'b1;
      wr_reg(8'h00, 5'h01);
      repeat (2) @(posedge clk) #1;
      chk({30'h0, run, halted}, 32'h2);
      wr_reg(8'h00, 5'h00);
      repeat (3) @(posedge clk) #1;
      chk({30'h0, flush, halted}, 32'h2);
      stall = 1'b0;
      for (int i = 0; i < 20 && halted !== 1'b1; i++) @(posedge clk) #1;
      chk({29'h0, busy, wbp, halted}, 32'h1);
    end
    $display("test stop done");
    // An error clears the run bit.
    wr_reg(8'h00, 5'h01);
    @(posedge clk) #1 err = 1'b1;
    @(posedge clk) #1 err = 1'b0;
    rd_reg(8'h00, v);
    chk(v, ctl(5'h00));
    $display("test error done");
    // Soft reset from this channel while busy, then from the peer channel.
    for (int p = 0; p < 2; p++) begin
      stall = 1'b1;
      wr_reg(8'h00, 5'h19);
      repeat (3) @(posedge clk) #1;
      if (p == 0) wr_reg(8'h00, 5'h04);
      else begin
        peer = 1'b1;
        @(posedge clk) #1 peer = 1'b0;
      end
      rd_reg(8'h00, v);
      chk(v, ctl(5'h04));
      chk({31'h0, sbusy}, 32'h1);
      chk({31'h0, clr}, 32'h0);
      stall = 1'b0;
      for (int i = 0; i < 30 && clr !== 1'b1; i++) @(posedge clk) #1;
      chk({31'h0, clr}, 32'h1);
      chk({31'h0, sbusy}, 32'h1);
      repeat (3) @(posedge clk) #1;
      rd_reg(8'h00, v);
      chk(v, ctl(5'h00));
      chk({30'h0, sbusy, halted}, 32'h1);
    end
    $display("test soft reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
